// File: rtl/dual_image_upgrade_control.sv
`timescale 1ns/1ps
module dual_image_upgrade_control #(
   parameter int WD_LOW_BITS = upgrade_pkg::WD_GRAIN
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic upgrade_if_clock,
   input wire logic shift_select,
   input wire logic capture_select,
   input wire logic serial_in,
   output logic serial_out,
   input wire logic internal_reload_req_n,
   input wire logic watchdog_restart_n,
   input wire logic remote_upgrade_en,
   input wire logic image_select_pin,
   input wire logic ext_reload_n,
   input wire logic crc_error,
   input wire logic status_n,
   input wire logic watchdog_enable_cfg,
   input wire logic [upgrade_pkg::WD_LIMIT_W-1:0] watchdog_limit_cfg,
   input wire logic encrypt_en,
   input wire upgrade_pkg::cfg_word_t cfg_in,
   input wire logic key_valid,
   input wire logic [31:0] key_stream,
   input wire logic load_done,
   output upgrade_pkg::stage_word_t core_out,
   output logic load_image,
   output logic loading,
   output logic in_user_mode,
   output logic watchdog_timeout
);

   ////////////////////////////////////////////////////////////////////////////
   // State record

   typedef struct packed {
      upgrade_pkg::msm_t msm;
      logic image;
      logic revert;
      logic [upgrade_pkg::SR_W-1:0] sr;
      logic [upgrade_pkg::IN_W-1:0] inreg;
      logic [upgrade_pkg::PREV_W-1:0] prev0;
      logic [upgrade_pkg::PREV_W-1:0] prev1;
      logic ifclk_q;
      logic [3:0] osc_cnt;
      logic osc_tick;
      logic io_seen;
      upgrade_pkg::stage_word_t dec;
      upgrade_pkg::stage_word_t out;
      logic timeout;
      logic loading;
      logic user;
   } ctrl_t;

   ctrl_t s_ff;
   ctrl_t nxt_s;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [3:0] msm_code(upgrade_pkg::msm_t m, logic img, logic rev);
      logic [3:0] c;
      c = upgrade_pkg::CODE_IDLE;
      if (m != upgrade_pkg::MSM_BOOT) begin
         if (img) begin
            c = rev ? upgrade_pkg::CODE_LOAD1_REV : upgrade_pkg::CODE_LOAD1;
         end else begin
            c = rev ? upgrade_pkg::CODE_LOAD0_REV : upgrade_pkg::CODE_LOAD0;
         end
      end
      return c;
   endfunction

   // Keeps only the highest raised source
   function automatic logic [3:0] top_source(logic [3:0] raw);
      logic [3:0] r;
      r = 4'h0;
      if (raw[3]) begin
         r = 4'h8;
      end else if (raw[2]) begin
         r = 4'h4;
      end else if (raw[1]) begin
         r = 4'h2;
      end else if (raw[0]) begin
         r = 4'h1;
      end
      return r;
   endfunction

   function automatic logic pick_image(logic [upgrade_pkg::IN_W-1:0] r, logic pin);
      logic img;
      img = pin;
      if (r[upgrade_pkg::OVR_BIT]) begin
         img = r[upgrade_pkg::IMG_SEL_BIT];
      end
      return img;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog

   logic wd_expired;
   logic wd_run;

   assign wd_run = (s_ff.msm == upgrade_pkg::MSM_USER) && watchdog_enable_cfg;

   user_watchdog #(
      .LOW_BITS(WD_LOW_BITS)
   ) u_watchdog (
      .clk(clk),
      .rst(rst),
      .run(wd_run),
      .tick(s_ff.osc_tick),
      .watchdog_restart_n(watchdog_restart_n),
      .limit(watchdog_limit_cfg),
      .expired(wd_expired)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Status words

   logic [3:0] code_now;
   logic [upgrade_pkg::CUR_W-1:0] cur_word;
   logic [3:0] raw_src;
   logic [3:0] src;
   logic internal_req;
   logic reload;

   always_comb begin
      code_now = msm_code(s_ff.msm, s_ff.image, s_ff.revert);
      // Reported limit always uses the documented grain
      cur_word = {code_now, watchdog_enable_cfg, watchdog_limit_cfg, 17'h0};
      raw_src = {~ext_reload_n, crc_error, ~status_n, wd_expired};
      src = top_source(raw_src);
      internal_req = !internal_reload_req_n && remote_upgrade_en;
      reload = (s_ff.msm == upgrade_pkg::MSM_USER) && ((|raw_src) || internal_req);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   logic if_rise;
   logic [upgrade_pkg::IN_W-1:0] cap_val;
   logic [upgrade_pkg::PREV_W-1:0] prev_word;
   logic dec_now;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.timeout = 1'b0;
      nxt_s.ifclk_q = upgrade_if_clock;
      if_rise = upgrade_if_clock && !s_ff.ifclk_q;

      // Oscillator stand-in: one-cycle tick every WD_OSC_DIV clocks
      nxt_s.osc_tick = 1'b0;
      if (s_ff.osc_cnt == 4'(upgrade_pkg::WD_OSC_DIV - 1)) begin
         nxt_s.osc_cnt = 4'h0;
         nxt_s.osc_tick = 1'b1;
      end else begin
         nxt_s.osc_cnt = s_ff.osc_cnt + 4'h1;
      end

      // Serial access
      case ({s_ff.sr[upgrade_pkg::SR_CAP_HI], s_ff.sr[upgrade_pkg::SR_CAP_LO]})
         upgrade_pkg::CAP_CURRENT: cap_val = upgrade_pkg::IN_W'(cur_word);
         upgrade_pkg::CAP_PREV0: cap_val = upgrade_pkg::IN_W'(s_ff.prev0);
         upgrade_pkg::CAP_PREV1: cap_val = upgrade_pkg::IN_W'(s_ff.prev1);
         default: cap_val = s_ff.inreg;
      endcase
      if (if_rise) begin
         if (shift_select) begin
            nxt_s.sr = {serial_in, s_ff.sr[upgrade_pkg::SR_W-1:1]};
         end else if (capture_select) begin
            nxt_s.sr[upgrade_pkg::IN_W-1:0] = cap_val;
         end else begin
            nxt_s.inreg = s_ff.sr[upgrade_pkg::IN_W-1:0];
         end
      end

      // Source record: reserved fields forced to zero
      prev_word = {src, 2'h0, code_now, 22'h0};

      // Loader pipeline: decrypt stage feeds a plain output register stage
      dec_now = encrypt_en && s_ff.io_seen && key_valid
         && (cfg_in.phase == upgrade_pkg::PH_CORE || cfg_in.phase == upgrade_pkg::PH_POSTAMBLE);
      nxt_s.dec.valid = 1'b0;
      nxt_s.out = s_ff.dec;

      case (s_ff.msm)
         upgrade_pkg::MSM_BOOT: begin
            nxt_s.msm = upgrade_pkg::MSM_LOAD;
            nxt_s.image = pick_image(s_ff.inreg, image_select_pin);
            nxt_s.revert = 1'b0;
            nxt_s.io_seen = 1'b0;
         end
         upgrade_pkg::MSM_LOAD: begin
            if (cfg_in.valid) begin
               nxt_s.dec.valid = 1'b1;
               nxt_s.dec.decrypted = dec_now;
               nxt_s.dec.data = dec_now ? (cfg_in.data ^ key_stream) : cfg_in.data;
               if (cfg_in.phase == upgrade_pkg::PH_IO_CHAIN) begin
                  nxt_s.io_seen = 1'b1;
               end
            end
            if (load_done) begin
               nxt_s.msm = upgrade_pkg::MSM_USER;
               nxt_s.inreg = upgrade_pkg::IN_RST;
               nxt_s.sr = upgrade_pkg::SR_RST;
            end
         end
         upgrade_pkg::MSM_USER: begin
            if (reload) begin
               if (s_ff.image) begin
                  nxt_s.prev1 = prev_word;
               end else begin
                  nxt_s.prev0 = prev_word;
               end
               nxt_s.msm = upgrade_pkg::MSM_LOAD;
               nxt_s.io_seen = 1'b0;
               if (src == 4'h1) begin
                  nxt_s.timeout = 1'b1;
                  nxt_s.image = ~s_ff.image;
                  nxt_s.revert = 1'b1;
               end else begin
                  nxt_s.image = pick_image(s_ff.inreg, image_select_pin);
                  nxt_s.revert = 1'b0;
               end
            end
         end
         default: begin
            nxt_s.msm = upgrade_pkg::MSM_BOOT;
         end
      endcase

      // Decoded one cycle early so the mode outputs leave straight from flops
      nxt_s.loading = (nxt_s.msm == upgrade_pkg::MSM_LOAD);
      nxt_s.user = (nxt_s.msm == upgrade_pkg::MSM_USER);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '{msm: upgrade_pkg::MSM_BOOT, image: 1'b0, revert: 1'b0,
                   sr: upgrade_pkg::SR_RST, inreg: upgrade_pkg::IN_RST,
                   prev0: upgrade_pkg::PREV_RST, prev1: upgrade_pkg::PREV_RST,
                   ifclk_q: 1'b0, osc_cnt: 4'h0, osc_tick: 1'b0, io_seen: 1'b0,
                   dec: '0, out: '0, timeout: 1'b0, loading: 1'b0, user: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state record

   assign serial_out = s_ff.sr[0];
   assign core_out = s_ff.out;
   assign load_image = s_ff.image;
   assign loading = s_ff.loading;
   assign in_user_mode = s_ff.user;
   assign watchdog_timeout = s_ff.timeout;

endmodule

// File: rtl/upgrade_pkg.sv
// Functional notes
// - Input register bit 13 picks image zero (0) or image one (1) on reload.
// - Input register bit 12 set lets bit 13 replace the select pin.
// - Bit 13 does nothing unless bit 12 is one; pin decides otherwise.
// - Current-state word bits 33:30 show the present state-machine code.
// - Current-state word bit 29 shows watchdog enable, active high.
// - Current-state word bits 28:0 show the whole 29-bit watchdog limit.
// - Previous-state flags: bit31 reload pin, 30 CRC, 29 status pin, 28 watchdog.
// - Simultaneous sources: only the highest bit is recorded; pin beats internal request.
// - Previous-state bits 25:22 hold the state-machine code at the event.
// - Code 0010 loads image zero, 0100 loads image one.
// - Code 0011 loads image one after revert, 0101 image zero after revert.
// - State machine tracks configuration mode and enables the watchdog.
// - Watchdog counter is 29 bits, only the upper 12 programmable, grain 2^17.
// - Watchdog advances on its own oscillator tick, not the user clock.
// - Watchdog starts counting once the application enters user mode.
// - Watchdog expiry raises time-out, records status, loads the revert image, unless pin, CRC or status fire in the same cycle.
// - Loading an application returns the control registers to reset values.
// - Loader decrypts incoming data first, then decompresses it; the code has no decompress stage, only an output register.
// - Decryption waits for the I/O chain; only core data and postamble decrypted.
// - Shift and capture selects low: copy shift register into input register.
// - Shift select high: shift one place per edge, serial input on top.
// - Capture picks by bits 40:39: current, previous zero, previous one, input.
// - Internal reload request low starts reconfiguration when remote upgrade enabled.
package upgrade_pkg;

   localparam int SR_W = 41;
   localparam int IN_W = 39;
   localparam int CUR_W = 34;
   localparam int PREV_W = 32;
   localparam int WD_W = 29;
   localparam int WD_LIMIT_W = 12;
   localparam int WD_GRAIN = 17;

   localparam int IMG_SEL_BIT = 13;
   localparam int OVR_BIT = 12;
   localparam int SR_CAP_HI = 40;
   localparam int SR_CAP_LO = 39;

   localparam logic [1:0] CAP_CURRENT = 2'h0;
   localparam logic [1:0] CAP_PREV0 = 2'h1;
   localparam logic [1:0] CAP_PREV1 = 2'h2;
   localparam logic [1:0] CAP_INPUT = 2'h3;

   localparam logic [3:0] CODE_IDLE = 4'h0;
   localparam logic [3:0] CODE_LOAD0 = 4'h2;
   localparam logic [3:0] CODE_LOAD1_REV = 4'h3;
   localparam logic [3:0] CODE_LOAD1 = 4'h4;
   localparam logic [3:0] CODE_LOAD0_REV = 4'h5;

   localparam logic [IN_W-1:0] IN_RST = 39'h0;
   localparam logic [SR_W-1:0] SR_RST = 41'h0;
   localparam logic [PREV_W-1:0] PREV_RST = 32'h0;

   localparam int CLK_PERIOD_NS = 25;
   localparam int RESTART_MIN_NS = 250;
   localparam int RESTART_CYCLES = (RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WD_OSC_DIV = 4;

   typedef enum logic [1:0] {MSM_BOOT, MSM_LOAD, MSM_USER} msm_t;
   typedef enum logic [1:0] {PH_HEADER, PH_IO_CHAIN, PH_CORE, PH_POSTAMBLE} phase_t;

   typedef struct packed {
      logic [31:0] data;
      logic valid;
      phase_t phase;
   } cfg_word_t;

   typedef struct packed {
      logic [31:0] data;
      logic valid;
      logic decrypted;
   } stage_word_t;

   typedef struct packed {
      logic [WD_W-1:0] cnt;
      logic [3:0] low_cnt;
      logic expired;
   } wd_state_t;

endpackage

// File: rtl/user_watchdog.sv
`timescale 1ns/1ps
module user_watchdog #(
   parameter int LOW_BITS = upgrade_pkg::WD_GRAIN
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic tick,
   input wire logic watchdog_restart_n,
   input wire logic [upgrade_pkg::WD_LIMIT_W-1:0] limit,
   output logic expired
);

   localparam logic [3:0] RESTART_LAST = 4'(upgrade_pkg::RESTART_CYCLES - 1);

   upgrade_pkg::wd_state_t s_ff;
   upgrade_pkg::wd_state_t nxt_s;
   logic [upgrade_pkg::WD_W-1:0] target;
   logic restart;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.expired = 1'b0;
      target = upgrade_pkg::WD_W'(limit) << LOW_BITS;
      // Short glitches on the restart line are not taken as a restart
      restart = !watchdog_restart_n && (s_ff.low_cnt == RESTART_LAST);
      if (watchdog_restart_n) begin
         nxt_s.low_cnt = 4'h0;
      end else if (s_ff.low_cnt != 4'(upgrade_pkg::RESTART_CYCLES)) begin
         nxt_s.low_cnt = s_ff.low_cnt + 4'h1;
      end
      if (!run || restart) begin
         nxt_s.cnt = '0;
      end else if (tick) begin
         if (s_ff.cnt + 29'h1 >= target) begin
            nxt_s.expired = 1'b1;
            nxt_s.cnt = '0;
         end else begin
            nxt_s.cnt = s_ff.cnt + 29'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign expired = s_ff.expired;

endmodule

// File: verification/upgrade_assertions.sv
`timescale 1ns/1ps
module upgrade_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic ext_reload_n,
   input wire logic internal_reload_req_n,
   input wire logic remote_upgrade_en,
   input wire logic encrypt_en,
   input wire logic key_valid,
   input wire upgrade_pkg::cfg_word_t cfg_in,
   input wire upgrade_pkg::stage_word_t core_out,
   input wire logic load_image,
   input wire logic loading,
   input wire logic in_user_mode,
   input wire logic watchdog_timeout
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   property p_ext; in_user_mode && !ext_reload_n |=> loading; endproperty
   a_ext: assert property (p_ext) else $error("reload pin missed");
   property p_int; in_user_mode && remote_upgrade_en && !internal_reload_req_n |=> loading; endproperty
   a_int: assert property (p_int) else $error("reload request missed");
   property p_excl; !(loading && in_user_mode); endproperty
   a_excl: assert property (p_excl) else $error("load and user together");
   property p_hold; in_user_mode && $past(in_user_mode) |-> $stable(load_image); endproperty
   a_hold: assert property (p_hold) else $error("image moved in user mode");
   property p_pulse; watchdog_timeout |=> !watchdog_timeout; endproperty
   a_pulse: assert property (p_pulse) else $error("timeout too long");
   property p_revert; watchdog_timeout |-> ##[0:1] loading; endproperty
   a_revert: assert property (p_revert) else $error("timeout without load");
   // Decrypt stage then output register stage: exactly two cycles from input word
   property p_order; $rose(core_out.valid) |-> $past(cfg_in.valid, 2) && $past(loading, 2); endproperty
   a_order: assert property (p_order) else $error("output without input");
   property p_dec;
      core_out.valid && core_out.decrypted |-> $past(encrypt_en && key_valid, 2) &&
         ($past(cfg_in.phase, 2) inside {upgrade_pkg::PH_CORE, upgrade_pkg::PH_POSTAMBLE});
   endproperty
   a_dec: assert property (p_dec) else $error("bad decryption");
   c_to: cover property (watchdog_timeout);
   c_dec: cover property (core_out.valid && core_out.decrypted);
   c_tie: cover property (in_user_mode && !ext_reload_n && !internal_reload_req_n);
endmodule
bind dual_image_upgrade_control upgrade_checker chk (.clk, .rst, .ext_reload_n, .internal_reload_req_n,
   .remote_upgrade_en, .encrypt_en, .key_valid, .cfg_in, .core_out, .load_image, .loading, .in_user_mode,
   .watchdog_timeout);

// File: verification/bridge_model.sv
`timescale 1ns/1ps
module bridge_model (
   input wire logic clk,
   input wire logic serial_out,
   output logic upgrade_if_clock,
   output logic shift_select,
   output logic capture_select,
   output logic serial_in,
   output logic watchdog_restart_n
);
   initial begin
      upgrade_if_clock = 1'b0;
      shift_select = 1'b0;
      capture_select = 1'b1;
      serial_in = 1'b0;
      watchdog_restart_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // Clock moves only inside transfers; idle data line toggles
   task automatic step(input logic s, input logic c, input logic d);
      @(negedge clk);
      shift_select = s;
      capture_select = c;
      serial_in = d;
      @(negedge clk);
      upgrade_if_clock = 1'b1;
      @(negedge clk);
      upgrade_if_clock = 1'b0;
      @(negedge clk);
   endtask
   task automatic shift41(input logic [40:0] w);
      for (int i = 0; i < 41; i++) step(1'b1, 1'b0, w[i]);
   endtask
   task automatic write_in(input logic [38:0] v);
      shift41({2'h0, v});
      step(1'b0, 1'b0, ~serial_in);
   endtask
   task automatic read_word(input logic [1:0] sel, output logic [38:0] r);
      shift41({sel, 39'h0});
      step(1'b0, 1'b1, ~serial_in);
      for (int i = 0; i < 39; i++) begin
         r[i] = serial_out;
         step(1'b1, 1'b0, ~serial_in);
      end
   endtask
   // One cycle over the minimum so the restart filter always accepts it
   task automatic restart();
      @(negedge clk);
      watchdog_restart_n = 1'b0;
      repeat (upgrade_pkg::RESTART_CYCLES + 1) @(negedge clk);
      watchdog_restart_n = 1'b1;
   endtask
endmodule

// File: verification/dual_image_upgrade_control_tb_top.sv
`timescale 1ns/1ps
module dual_image_upgrade_control_tb_top;
   logic clk, rst, upgrade_if_clock, shift_select, capture_select, serial_in, serial_out;
   logic internal_reload_req_n, watchdog_restart_n, remote_upgrade_en, image_select_pin, ext_reload_n;
   logic crc_error, status_n, watchdog_enable_cfg, encrypt_en, key_valid, load_done;
   logic load_image, loading, in_user_mode, watchdog_timeout;
   logic [11:0] watchdog_limit_cfg;
   logic [31:0] key_stream;
   logic [38:0] r;
   upgrade_pkg::cfg_word_t cfg_in;
   upgrade_pkg::stage_word_t core_out;
   int err_total, n_checks, to_cnt;
   dual_image_upgrade_control #(.WD_LOW_BITS(2)) uut (.clk, .rst, .upgrade_if_clock, .shift_select,
      .capture_select, .serial_in, .serial_out, .internal_reload_req_n, .watchdog_restart_n, .remote_upgrade_en,
      .image_select_pin, .ext_reload_n, .crc_error, .status_n, .watchdog_enable_cfg, .watchdog_limit_cfg,
      .encrypt_en, .cfg_in, .key_valid, .key_stream, .load_done, .core_out, .load_image, .loading,
      .in_user_mode, .watchdog_timeout);
   bridge_model bm (.clk, .serial_out, .upgrade_if_clock, .shift_select, .capture_select, .serial_in,
      .watchdog_restart_n);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(negedge clk) if (watchdog_timeout === 1'b1) to_cnt++;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [40:0] got, input logic [40:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cfgw(input upgrade_pkg::phase_t ph, input logic [31:0] d, input logic dec);
      cfg_in = '{d, 1'b1, ph};
      @(negedge clk);
      cfg_in.valid = 1'b0;
      for (int i = 0; i < 3 && core_out.valid !== 1'b1; i++) @(negedge clk);
      chk({core_out.valid, core_out.decrypted, core_out.data}, {1'b1, dec, dec ? d ^ key_stream : d});
   endtask
   task automatic app_loaded();
      @(negedge clk);
      load_done = 1'b1;
      @(negedge clk);
      load_done = 1'b0;
      @(negedge clk);
      chk(in_user_mode, 1'b1);
   endtask
   task automatic reload(input logic ext_n, input logic int_n);
      @(negedge clk);
      ext_reload_n = ext_n;
      internal_reload_req_n = int_n;
      @(negedge clk);
      ext_reload_n = 1'b1;
      internal_reload_req_n = 1'b1;
      @(negedge clk);
   endtask
   initial begin
      #300us;
      err_total++;
      test_done();
   end
   initial begin
      {rst, remote_upgrade_en, status_n, ext_reload_n, internal_reload_req_n, encrypt_en} = 6'h3F;
      {image_select_pin, crc_error, watchdog_enable_cfg, key_valid, load_done} = 5'h0;
      watchdog_limit_cfg = 12'h003;
      key_stream = 32'hA5C3_0F96;
      cfg_in = '0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk({loading, load_image}, 2'h2);
      cfgw(upgrade_pkg::PH_HEADER, 32'h1234_5678, 1'b0);
      key_valid = 1'b1;
      cfgw(upgrade_pkg::PH_CORE, 32'h0BAD_F00D, 1'b0);
      cfgw(upgrade_pkg::PH_IO_CHAIN, 32'h0000_FFFF, 1'b0);
      cfgw(upgrade_pkg::PH_CORE, 32'hCAFE_0001, 1'b1);
      cfgw(upgrade_pkg::PH_POSTAMBLE, 32'h8000_0002, 1'b1);
      app_loaded();
      bm.read_word(upgrade_pkg::CAP_CURRENT, r);
      chk(r, {5'h0, upgrade_pkg::CODE_LOAD0, 1'b0, 12'h003, 17'h0});
      bm.write_in(39'h3000);
      bm.read_word(upgrade_pkg::CAP_INPUT, r);
      chk(r, 39'h3000);
      reload(1'b0, 1'b0);
      chk({loading, load_image}, 2'h3);
      app_loaded();
      bm.read_word(upgrade_pkg::CAP_PREV0, r);
      chk(r, {7'h0, 4'h8, 2'h0, upgrade_pkg::CODE_LOAD0, 22'h0});
      bm.read_word(upgrade_pkg::CAP_INPUT, r);
      chk(r, 39'h0);
      bm.read_word(upgrade_pkg::CAP_CURRENT, r);
      chk(r[38:30], {5'h0, upgrade_pkg::CODE_LOAD1});
      remote_upgrade_en = 1'b0;
      reload(1'b1, 1'b0);
      chk(loading, 1'b0);
      remote_upgrade_en = 1'b1;
      bm.write_in(39'h2000);
      reload(1'b1, 1'b0);
      chk(load_image, 1'b0);
      app_loaded();
      image_select_pin = 1'b1;
      watchdog_enable_cfg = 1'b1;
      bm.restart();
      repeat (4) begin
         repeat (30) @(negedge clk);
         bm.restart();
      end
      chk(to_cnt, 0);
      for (int i = 0; i < 200 && to_cnt == 0; i++) @(negedge clk);
      chk(to_cnt, 1);
      chk({loading, load_image}, 2'h3);
      watchdog_limit_cfg = 12'hFFF;
      app_loaded();
      bm.read_word(upgrade_pkg::CAP_CURRENT, r);
      chk(r, {5'h0, upgrade_pkg::CODE_LOAD1_REV, 1'b1, 12'hFFF, 17'h0});
      bm.read_word(upgrade_pkg::CAP_PREV0, r);
      chk(r, {7'h0, 4'h1, 2'h0, upgrade_pkg::CODE_LOAD0, 22'h0});
      // Expiry from the reverted image: pin says one, revert must pick zero
      watchdog_limit_cfg = 12'h001;
      for (int i = 0; i < 200 && to_cnt == 1; i++) @(negedge clk);
      chk(to_cnt, 2);
      chk({loading, load_image}, 2'h2);
      watchdog_enable_cfg = 1'b0;
      app_loaded();
      bm.read_word(upgrade_pkg::CAP_CURRENT, r);
      chk(r[38:29], {5'h0, upgrade_pkg::CODE_LOAD0_REV, 1'b0});
      bm.read_word(upgrade_pkg::CAP_PREV1, r);
      chk(r, {7'h0, 4'h1, 2'h0, upgrade_pkg::CODE_LOAD1_REV, 22'h0});
      test_done();
   end
endmodule
